// *** common/isa_bus_defs.svh ***
// Timing counts and encodings for the ISA bus cycle engine.
// Assumes a 20 MHz core clock; the bus clock is derived from it.
`ifndef ISA_BUS_DEFS_SVH
`define ISA_BUS_DEFS_SVH
`define CORE_CLK_NS        50
`define BCLK_PERIOD_NS     400
`define BCLK_HALF_CYC      (`BCLK_PERIOD_NS / `CORE_CLK_NS / 2)
`define BCLK_DIV_W         3
`define READY_TIMER_W      4
`define READY_BCLKS_8BIT   4'h6
`define READY_BCLKS_16BIT  4'h3
`define LOW_MEG_TOP        24'h100000
`define ADDR_W             24
`define CYC_MEM_RD         2'h0
`define CYC_MEM_WR         2'h1
`define CYC_IO_RD          2'h2
`define CYC_IO_WR          2'h3
`endif

// *** common/isa_bus_pkg.sv ***
// Types shared by the ISA bus cycle engine.
// Constants live in isa_bus_defs.svh.
package isa_bus_pkg;
  typedef struct packed {
    logic [1:0]  kind;
    logic        dma;
    logic        hi_byte;
    logic [23:0] addr;
  } isa_req_t;

  typedef struct packed {
    logic        done;
    logic        width16;
    logic        early;
  } isa_resp_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_CMD    = 3'b011,
    ST_END    = 3'b010,
    ST_MASTER = 3'b110
  } isa_state_t;
endpackage

// *** hdl/isa_bus_interface.sv ***
// ISA bus cycle engine: runs memory and I/O cycles for internal requesters,
// derives the bus clock, yields command lines to an ISA master.
// Assumes requests come from logic on core_clk; bus inputs are asynchronous.
//
// Functional notes
// RULE1: Drive memory strobes, inputs under ISA master
// RULE2: Drive I/O strobes, inputs under ISA master
// RULE3: Bus owner drives upper address 23..17
// RULE4: Low address lines carry memory/IO address
// RULE5: Zero-wait input ends cycle early
// RULE6: Byte-high enable asserted for upper lane
// RULE7: Memory 16-bit select chooses cycle width
// RULE8: I/O 16-bit select sizes I/O cycle
// RULE9: Channel check input flagged as error
// RULE10: Refresh line driven open drain
// RULE11: Master input turns command lines around
// RULE12: Low-memory strobes only below first megabyte
// RULE13: Channel-ready low stretches the cycle
// RULE14: Address latch enable marks valid address
// RULE15: Address enable held through DMA cycles
// RULE16: Bus clock free-running, times all phases
// RULE17: Ready count ends cycle; extension beats early
`timescale 1ns/100ps
`include "isa_bus_defs.svh"
module isa_bus_interface (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire isa_bus_pkg::isa_req_t  req,
  input  wire logic                   req_valid,
  input  wire logic                   refresh_req,
  output logic                        req_ready,
  output isa_bus_pkg::isa_resp_t      resp,
  output logic                        chk_error,
  output logic                        bclk,
  output logic [23:0]                 addr_out,
  output logic                        addr_oe,
  input  wire logic [23:0]            addr_in,
  output logic [3:0]                  cmd_out_n,
  output logic                        cmd_oe,
  input  wire logic [3:0]             cmd_in_n,
  output logic                        sbhe_out_n,
  input  wire logic                   sbhe_in_n,
  output logic                        smemr_n,
  output logic                        smemw_n,
  output logic                        bale,
  output logic                        aen,
  output logic                        refresh_out_n,
  output logic                        refresh_oe,
  input  wire logic                   refresh_in_n,
  input  wire logic                   zws_n,
  input  wire logic                   iochrdy,
  input  wire logic                   m16_n,
  input  wire logic                   io16_n,
  input  wire logic                   iochk_n,
  input  wire logic                   master_n,
  output logic                        master_active,
  output logic [23:0]                 master_addr,
  output logic [3:0]                  master_cmd_n,
  output logic                        master_sbhe_n
);
  import isa_bus_pkg::*;

  // Two-flop synchronisers; stage one is read only by stage two
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  wire  [NSYNC-1:0] raw_in = {refresh_in_n, sbhe_in_n, cmd_in_n, zws_n, iochrdy,
                              m16_n, io16_n};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        sync1[gi] <= rst ? 1'b1 : raw_in[gi];
        sync2[gi] <= rst ? 1'b1 : sync1[gi];
      end
    end
  endgenerate
  logic [1:0] chk_s;
  logic [1:0] mst_s;
  logic [23:0] addr_s1;
  logic [23:0] addr_s2;
  always_ff @(posedge core_clk) begin
    chk_s   <= rst ? 2'b11 : {chk_s[0], iochk_n};
    mst_s   <= rst ? 2'b11 : {mst_s[0], master_n};
    addr_s1 <= addr_in;
    addr_s2 <= addr_s1;
  end
  wire io16_s    = ~sync2[0];
  wire m16_s     = ~sync2[1];
  wire rdy_s     = sync2[2];
  wire zws_s     = ~sync2[3];
  wire [3:0] cin = sync2[7:4];
  wire sbhe_s    = sync2[8];
  wire master_s  = ~mst_s[1];

  // Bus clock divider; the rising edge enable paces every cycle phase [RULE16]
  logic [`BCLK_DIV_W-1:0] div_cnt;
  wire div_wrap = (div_cnt == `BCLK_DIV_W'(`BCLK_HALF_CYC - 1));
  wire bclk_rise = div_wrap & ~bclk;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= '0;
      bclk    <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
      bclk    <= div_wrap ? ~bclk : bclk; // [RULE16]
    end
  end

  isa_state_t state;
  isa_state_t next_state;
  isa_req_t   cur;
  logic [`READY_TIMER_W-1:0] timer;
  logic       width16;

  // Width decision from slave selects [RULE7] [RULE8]
  wire is_mem      = ~cur.kind[1];
  wire sel16       = is_mem ? m16_s : io16_s;
  wire timer_out   = (timer == '0);
  // Ready low stretches; zero-wait cannot override it [RULE13] [RULE17]
  wire end_early   = zws_s & rdy_s; // [RULE5]
  wire end_cycle   = rdy_s & (timer_out | end_early); // [RULE17]
  wire low_meg     = (cur.addr < `ADDR_W'(`LOW_MEG_TOP)); // [RULE12]
  wire start       = req_valid & (state == ST_IDLE) & ~master_s;

  // Cycle sequencer: address phase, command phase, end phase
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   next_state = master_s ? ST_MASTER : (start ? ST_ADDR : ST_IDLE);
      ST_ADDR:   next_state = bclk_rise ? ST_CMD : ST_ADDR;
      ST_CMD:    next_state = (bclk_rise & end_cycle) ? ST_END : ST_CMD;
      ST_END:    next_state = bclk_rise ? ST_IDLE : ST_END;
      ST_MASTER: next_state = master_s ? ST_MASTER : ST_IDLE; // [RULE11]
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      cur   <= '0;
    end else begin
      state <= next_state;
      if (start)
        cur <= req;
    end
  end

  // Ready timer loaded at command start, counted on bus clock edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer   <= '0;
      width16 <= 1'b0;
    end else if (state == ST_ADDR && bclk_rise) begin
      width16 <= sel16;
      timer   <= sel16 ? `READY_BCLKS_16BIT : `READY_BCLKS_8BIT;
    end else if (state == ST_CMD && bclk_rise && !timer_out) begin
      timer <= timer - 1'b1;
    end
  end

  // Request seen by the pins; on the start edge cur is still stale,
  // so the fresh request feeds address, byte enable and aen directly
  isa_req_t src;
  assign src = start ? req : cur;

  // Bus pin drive, decided from next state so outputs leave flops
  wire own      = (next_state == ST_ADDR) | (next_state == ST_CMD) | (next_state == ST_END);
  wire cmd_on   = (next_state == ST_CMD);
  wire [3:0] strobe_n = ~({4{cmd_on}} & (4'h1 << src.kind)); // [RULE1] [RULE2]
  wire [23:0] bus_addr = src.kind[1] ? {8'h00, src.addr[15:0]} : src.addr; // [RULE3] [RULE4]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_out   <= '0;
      addr_oe    <= 1'b0;
      cmd_out_n  <= 4'hF;
      cmd_oe     <= 1'b0;
      sbhe_out_n <= 1'b1;
      smemr_n    <= 1'b1;
      smemw_n    <= 1'b1;
      bale       <= 1'b0;
      aen        <= 1'b0;
    end else begin
      addr_out   <= bus_addr;
      addr_oe    <= own & ~master_s; // [RULE3] [RULE11]
      cmd_out_n  <= strobe_n;
      cmd_oe     <= own & ~master_s; // [RULE1] [RULE2] [RULE11]
      sbhe_out_n <= ~(own & ~master_s & src.hi_byte); // [RULE6]
      smemr_n    <= ~(cmd_on & low_meg & (cur.kind == `CYC_MEM_RD)); // [RULE12]
      smemw_n    <= ~(cmd_on & low_meg & (cur.kind == `CYC_MEM_WR)); // [RULE12]
      bale       <= (next_state == ST_ADDR); // [RULE14]
      aen        <= own & src.dma; // [RULE15]
    end
  end

  // Open-drain refresh: only ever pulls low, else released [RULE10]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      refresh_out_n <= 1'b0;
      refresh_oe    <= 1'b0;
    end else begin
      refresh_out_n <= 1'b0;
      // Next state, not present: never pull while a cycle is launching
      refresh_oe    <= refresh_req & (next_state == ST_IDLE) & ~master_s; // [RULE10]
    end
  end

  // Handshake, status, error and master-side observation
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_ready     <= 1'b0;
      resp          <= '0;
      chk_error     <= 1'b0;
      master_active <= 1'b0;
      master_addr   <= '0;
      master_cmd_n  <= 4'hF;
      master_sbhe_n <= 1'b1;
    end else begin
      req_ready     <= (next_state == ST_IDLE) & ~master_s;
      resp.done     <= (state == ST_END) & bclk_rise;
      resp.width16  <= width16; // [RULE7] [RULE8]
      if (state == ST_CMD && bclk_rise && end_cycle)
        resp.early  <= end_early & ~timer_out; // [RULE5]
      chk_error     <= ~chk_s[1]; // [RULE9]
      master_active <= master_s; // [RULE11]
      master_addr   <= master_s ? addr_s2 : '0;
      master_cmd_n  <= master_s ? cin : 4'hF; // [RULE1] [RULE2]
      master_sbhe_n <= master_s ? sbhe_s : 1'b1;
    end
  end
endmodule

// *** verif/isa_bus_asserts.sv ***
// Checker bound to the ISA cycle engine top module.
// Assumes the bus inputs are driven from the core clock domain.
`timescale 1ns/100ps
module isa_bus_asserts (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        bclk,
  input wire logic [23:0] addr_out,
  input wire logic        addr_oe,
  input wire logic [3:0]  cmd_out_n,
  input wire logic        cmd_oe,
  input wire logic        sbhe_out_n,
  input wire logic        smemr_n,
  input wire logic        bale,
  input wire logic        refresh_out_n,
  input wire logic        refresh_oe,
  input wire logic        chk_error,
  input wire logic        iochk_n,
  input wire logic        master_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Ownership, address, strobe, channel check, refresh and bus clock relations
  a_master_yield: assert property (master_active |-> !cmd_oe && !addr_oe)
    else $error("bus driven under a foreign master");
  a_io_addr: assert property (addr_oe && cmd_out_n[3:2] != 2'h3 |-> addr_out[23:16] == 8'h00)
    else $error("upper address set in io cycle");
  a_low_meg: assert property (!smemr_n |-> !cmd_out_n[0] && addr_out < 24'h100000)
    else $error("low memory strobe out of range");
  a_sbhe_owner: assert property (!sbhe_out_n |-> addr_oe)
    else $error("byte high enable without ownership");
  a_chk_flag: assert property ($fell(iochk_n) ##1 !iochk_n [*4] |-> chk_error)
    else $error("channel check not flagged");
  a_refresh_od: assert property (refresh_oe |-> !refresh_out_n && !cmd_oe)
    else $error("refresh line not pulled low");
  a_bale_addr: assert property ($rose(bale) |-> addr_oe && cmd_out_n == 4'hF)
    else $error("latch enable without address");
  a_bclk_run: assert property ($rose(bclk) |=> bclk [*3] ##1 !bclk [*4])
    else $error("bus clock period wrong");
endmodule
bind isa_bus_interface isa_bus_asserts u_chk (.core_clk, .rst, .bclk, .addr_out, .addr_oe,
  .cmd_out_n, .cmd_oe, .sbhe_out_n, .smemr_n, .bale, .refresh_out_n, .refresh_oe,
  .chk_error, .iochk_n, .master_active);

// *** verif/isa_slave_model.sv ***
// Slave population model: width select, zero-wait and ready stretch.
// Assumes mode and wide change only while the bus is idle.
`timescale 1ns/100ps
module isa_slave_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] cmd_out_n,
  input  wire logic [1:0] mode,
  input  wire logic       wide,
  output logic            zws_n,
  output logic            iochrdy,
  output logic            m16_n,
  output logic            io16_n
);
  logic [5:0] hold;
  wire        strobe = cmd_out_n != 4'hF;
  // Open-collector lines fall back high through pull-ups when released
  assign m16_n   = !wide;
  assign io16_n  = !wide;
  assign zws_n   = !(mode == 2'h1 && strobe);
  assign iochrdy = !(mode == 2'h2 && strobe && hold != 6'h00);
  // Stretch counts from the strobe edge, long enough to outlast any timer
  always_ff @(posedge core_clk) begin
    if (!strobe) hold <= 6'h3C;
    else if (hold != 6'h00) hold <= hold - 6'h01;
  end
endmodule

// *** verif/tb_top.sv ***
// Testbench: random and corner ISA cycles against the slave model.
// Assumes package, design, checker and slave model compile first.
`timescale 1ns/100ps
module tb_top;
  import isa_bus_pkg::*;
  logic core_clk = 0, rst = 1, req_valid = 0, refresh_req = 0, wide = 0;
  logic iochk_n = 1, master_n = 1, sbhe_in_n = 1, refresh_in_n = 1;
  logic [1:0]  mode = 2'h0;
  logic [3:0]  cmd_in_n = 4'hF, cmd_out_n, master_cmd_n;
  logic [23:0] addr_in = '0, addr_out, master_addr;
  logic req_ready, chk_error, bclk, addr_oe, cmd_oe, sbhe_out_n, smemr_n, smemw_n, bale, aen;
  logic refresh_out_n, refresh_oe, zws_n, iochrdy, m16_n, io16_n, master_active, master_sbhe_n;
  isa_req_t    req = '0;
  isa_resp_t   resp;
  int          mismatches = 0, total_checks = 0, lo;
  logic [31:0] seed = 32'hD15A80AC;
  always #25 core_clk = ~core_clk;
  isa_bus_interface DUT (.*);
  isa_slave_model slave (.core_clk, .cmd_out_n, .mode, .wide, .zws_n, .iochrdy, .m16_n, .io16_n);
  // Expectation helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic in_range(int n, logic [1:0] m, logic w);
    int t;
    t = w ? 24 : 48;
    if (m == 2'h1) return n <= 16;
    if (m == 2'h2) return n >= 60;
    return n >= t && n <= t + 8;
  endfunction
  function automatic logic cond(int k);
    case (k)
      0: return cmd_out_n !== 4'hF;
      1: return cmd_out_n === 4'hF;
      2: return resp.done === 1'b1;
      default: return req_ready === 1'b1;
    endcase
  endfunction
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait, sampling on the falling edge where outputs are settled
  task automatic wait_on(int k);
    lo = 0;
    while (!cond(k)) begin
      @(negedge core_clk);
      lo++;
      if (lo > 400) begin
        mismatches++;
        final_report();
      end
    end
  endtask
  task automatic run_one(isa_req_t r, logic [1:0] m, logic w);
    wait_on(3);
    @(posedge core_clk);
    mode <= m;
    wide <= w;
    req <= r;
    repeat (3) @(posedge core_clk);
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    wait_on(0);
    chk("cmd", {20'h0, ~(4'h1 << r.kind)}, {20'h0, cmd_out_n});
    chk("addr", r.kind[1] ? {8'h00, r.addr[15:0]} : r.addr, addr_out);
    chk("aen", r.dma, aen);
    chk("sbhe", !r.hi_byte, sbhe_out_n);
    chk("smemr", !(r.kind == 2'h0 && r.addr < 24'h100000), smemr_n);
    chk("smemw", !(r.kind == 2'h1 && r.addr < 24'h100000), smemw_n);
    chk("oe", 24'h000003, {addr_oe, cmd_oe});
    wait_on(1);
    chk("len", 1'b1, in_range(lo, m, w));
    wait_on(2);
    chk("width", w, resp.width16);
    chk("early", m == 2'h1, resp.early);
  endtask
  // Main sequence: table of kinds and modes first, then random traffic, then side inputs
  initial begin
    isa_req_t r;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 36; i++) begin
      r = 28'(rnd());
      if (i < 12) r.kind = i[1:0];
      if (i == 12 || i == 13) r.kind = 2'h0;
      if (i == 14) r.kind = 2'h1;
      if (i == 12 || i == 14) r.addr = 24'h0FFFFF;
      if (i == 13) r.addr = 24'h100000;
      run_one(r, (i < 12) ? i[3:2] : 2'(rnd() % 3), 1'(rnd()));
    end
    $display("test cycles done");
    @(posedge core_clk);
    refresh_req <= 1'b1;
    iochk_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk("refresh_oe", 1'b1, refresh_oe);
    chk("chk_error", 1'b1, chk_error);
    @(posedge core_clk);
    refresh_req <= 1'b0;
    iochk_n <= 1'b1;
    addr_in <= 24'(rnd());
    cmd_in_n <= 4'hE;
    sbhe_in_n <= 1'b0;
    master_n <= 1'b0;
    // Let the master input pass its synchroniser before the request
    repeat (3) @(posedge core_clk);
    req_valid <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("chk_clear", 1'b0, chk_error);
    chk("master", 24'h000004, {master_active, req_ready, cmd_oe});
    chk("m_addr", addr_in, master_addr);
    chk("m_cmd", 24'h00000E, {master_sbhe_n, master_cmd_n});
    @(posedge core_clk);
    master_n <= 1'b1;
    req_valid <= 1'b0;
    cmd_in_n <= 4'hF;
    sbhe_in_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("refused", 1'b1, req_ready);
    $display("test side inputs done");
    run_one(r, 2'h0, 1'b1);
    final_report();
  end
endmodule
